//--- pwr_pkg.sv
// Shared constants and types for the power switch state control
package pwr_pkg;

    // Standby clock rate
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;

    // Press timing in milliseconds, as the figures are given
    localparam int unsigned SHORT_HOLD_MS   = 4000;
    localparam int unsigned LONG_HOLD_MS    = 6000;
    localparam int unsigned DEBOUNCE_MS     = 20;

    // Cycle counts; all divide exactly at this rate, so no rounding is lost
    localparam int unsigned SHORT_HOLD_CYC  = SHORT_HOLD_MS * CYC_PER_MS;
    localparam int unsigned LONG_HOLD_CYC   = LONG_HOLD_MS * CYC_PER_MS;
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CYC_PER_MS;

    // Cycles after reset before the sense pins are trusted
    localparam logic [3:0]  SYNC_SETTLE_CYC = 4'h8;

    // Reset levels of the synchronised pins
    localparam logic        SW_IDLE_LEVEL   = 1'h1;
    localparam logic        SENSE_OK_LEVEL  = 1'h1;

    // Encoding of the reported system state
    localparam logic [1:0]  CODE_SOFT_OFF   = 2'h0;
    localparam logic [1:0]  CODE_WORKING    = 2'h1;
    localparam logic [1:0]  CODE_SLEEPING   = 2'h2;

    typedef enum logic [1:0] {
        st_soft_off,
        st_working,
        st_sleeping
    } pstate_e;

endpackage

//--- sync_filter.sv
// Three-stage pin synchroniser with a stability filter
`timescale 1ns/1ns
module sync_filter #(
    parameter int unsigned STABLE_CYC = 1,
    parameter logic        RESET_VAL  = 1'h0
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Raw pin and filtered level
    input  wire logic raw,
    output logic      level
);
    localparam int unsigned CW = $clog2(STABLE_CYC + 1);

    logic          s1;
    logic          s2;
    logic          s3;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_level;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    always_comb begin
        next_cnt   = '0;
        next_level = level;
        if (s2 == s3 && s3 != level) begin
            if (cnt == CW'(STABLE_CYC - 1)) begin
                next_level = s3;
            end else begin
                next_cnt = cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1    <= RESET_VAL;
            s2    <= RESET_VAL;
            s3    <= RESET_VAL;
            cnt   <= '0;
            level <= RESET_VAL;
        end else begin
            s1    <= raw;
            s2    <= s1;
            s3    <= s2;
            cnt   <= next_cnt;
            level <= next_level;
        end
    end

endmodule

//--- power_switch_state_control.sv
// Power switch press timing and system power state control
//
// Function
// - Off, short press: power on to working
// - Working, short press: request sleep per policy
// - Working, over six seconds: forced soft-off
// - Sleeping, short press: wake to working
// - Sleeping, over six seconds: soft-off
// - Power-on allowed without clock battery
// - Battery and mains lost: clear time, flag
`timescale 1ns/1ns
module power_switch_state_control #(
    parameter int unsigned SHORT_HOLD_CYC = pwr_pkg::SHORT_HOLD_CYC,
    parameter int unsigned LONG_HOLD_CYC  = pwr_pkg::LONG_HOLD_CYC,
    parameter int unsigned DEBOUNCE_CYC   = pwr_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Front panel switch, low while pressed
    input  wire logic       pwr_sw_n,
    // Sense pins
    input  wire logic       rtc_batt_ok,
    input  wire logic       mains_ok,
    // Operating system
    input  wire logic       os_sleep_allow,
    input  wire logic       os_soft_off_req,
    input  wire logic       post_ack,
    // State and indications
    output logic [1:0]      sys_state,
    output logic            pwr_en,
    output logic            sleep_req,
    output logic            rtc_clear,
    output logic            time_lost
);
    localparam int unsigned CW = $clog2(LONG_HOLD_CYC + 1);

    function automatic logic [1:0] state_code(input pwr_pkg::pstate_e s);
        case (s)
            pwr_pkg::st_working:  state_code = pwr_pkg::CODE_WORKING;
            pwr_pkg::st_sleeping: state_code = pwr_pkg::CODE_SLEEPING;
            default:              state_code = pwr_pkg::CODE_SOFT_OFF;
        endcase
    endfunction

    logic            sw_level;
    logic            batt_s;
    logic            mains_s;

    // Switch filtered against bounce, sense pins only synchronised
    sync_filter #(.STABLE_CYC(DEBOUNCE_CYC), .RESET_VAL(pwr_pkg::SW_IDLE_LEVEL)) u_sw_filter (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .raw      (pwr_sw_n),
        .level    (sw_level)
    );

    sync_filter #(.STABLE_CYC(1), .RESET_VAL(pwr_pkg::SENSE_OK_LEVEL)) u_batt_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .raw      (rtc_batt_ok),
        .level    (batt_s)
    );

    sync_filter #(.STABLE_CYC(1), .RESET_VAL(pwr_pkg::SENSE_OK_LEVEL)) u_mains_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .raw      (mains_ok),
        .level    (mains_s)
    );

    // Press timing group
    logic            pressed;
    logic            pressed_q;
    logic [CW-1:0]   cnt;
    logic [CW-1:0]   next_cnt;
    logic            rel;
    logic            short_rel;
    logic            long_hit;

    assign pressed   = ~sw_level;
    assign rel       = pressed_q & ~pressed;
    // Count holds the press length in cycles at the release cycle
    assign short_rel = rel && (cnt < CW'(SHORT_HOLD_CYC));
    assign long_hit  = pressed && (cnt == CW'(LONG_HOLD_CYC - 1));

    // Saturation keeps a forced-off press from acting again on release
    always_comb begin
        next_cnt = '0;
        if (pressed) begin
            next_cnt = (cnt == CW'(LONG_HOLD_CYC)) ? cnt : cnt + CW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pressed_q <= 1'b0;
            cnt       <= '0;
        end else begin
            pressed_q <= pressed;
            cnt       <= next_cnt;
        end
    end

    // Power state group
    pwr_pkg::pstate_e state;
    pwr_pkg::pstate_e next_state;
    logic [1:0]       next_sys_state;
    logic             next_pwr_en;
    logic             next_sleep_req;

    // Battery level never gates power-on, so a missing cell cannot block it
    always_comb begin
        next_state     = state;
        next_sleep_req = 1'b0;
        case (state)
            pwr_pkg::st_soft_off: begin
                if (short_rel) begin
                    next_state = pwr_pkg::st_working;
                end
            end
            pwr_pkg::st_working: begin
                if (long_hit) begin
                    next_state = pwr_pkg::st_soft_off;
                end else if (os_soft_off_req) begin
                    next_state = pwr_pkg::st_soft_off;
                end else if (short_rel) begin
                    next_sleep_req = 1'b1;
                    if (os_sleep_allow) begin
                        next_state = pwr_pkg::st_sleeping;
                    end
                end
            end
            pwr_pkg::st_sleeping: begin
                if (long_hit) begin
                    next_state = pwr_pkg::st_soft_off;
                end else if (short_rel) begin
                    next_state = pwr_pkg::st_working;
                end
            end
            default: begin
                next_state = pwr_pkg::st_soft_off;
            end
        endcase
        next_sys_state = state_code(next_state);
        next_pwr_en    = (state_code(next_state) == pwr_pkg::CODE_WORKING);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state     <= pwr_pkg::st_soft_off;
            sys_state <= pwr_pkg::CODE_SOFT_OFF;
            pwr_en    <= 1'b0;
            sleep_req <= 1'b0;
        end else begin
            state     <= next_state;
            sys_state <= next_sys_state;
            pwr_en    <= next_pwr_en;
            sleep_req <= next_sleep_req;
        end
    end

    // Time loss group
    logic [3:0]      settle_cnt;
    logic [3:0]      next_settle_cnt;
    logic            settled;
    logic            next_settled;
    logic            first_check;
    logic            loss_now;
    logic            loss_q;
    logic            next_rtc_clear;
    logic            next_time_lost;

    // Reset release means mains just returned; the synchronisers need time first
    assign first_check = !settled && (settle_cnt == pwr_pkg::SYNC_SETTLE_CYC - 4'h1);
    assign loss_now    = (settled || first_check) && !batt_s && (!mains_s || first_check);

    // A loss in the same cycle as the firmware ack keeps the flag set
    always_comb begin
        next_settle_cnt = settle_cnt;
        next_settled    = settled;
        if (!settled) begin
            next_settle_cnt = settle_cnt + 4'h1;
            next_settled    = first_check;
        end
        next_rtc_clear = loss_now && !loss_q;
        next_time_lost = next_rtc_clear || (time_lost && !post_ack);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_cnt <= 4'h0;
            settled    <= 1'b0;
            loss_q     <= 1'b0;
            rtc_clear  <= 1'b0;
            time_lost  <= 1'b0;
        end else begin
            settle_cnt <= next_settle_cnt;
            settled    <= next_settled;
            loss_q     <= loss_now;
            rtc_clear  <= next_rtc_clear;
            time_lost  <= next_time_lost;
        end
    end

    // Checks
    sequence s_sleep_pulse;
        sleep_req ##1 !sleep_req;
    endsequence

    sequence s_clear_pulse;
        (rtc_clear && time_lost) ##1 !rtc_clear;
    endsequence

    a_off_power_on: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sys_state == pwr_pkg::CODE_SOFT_OFF && short_rel)
        |=> (sys_state == pwr_pkg::CODE_WORKING && pwr_en))
        else $error("short press from soft-off did not power on");

    a_work_sleep_req: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sys_state == pwr_pkg::CODE_WORKING && short_rel && !long_hit && !os_soft_off_req)
        |=> s_sleep_pulse)
        else $error("short press while working gave no sleep request pulse");

    a_work_force_off: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sys_state == pwr_pkg::CODE_WORKING && long_hit)
        |=> (sys_state == pwr_pkg::CODE_SOFT_OFF && !pwr_en)[*2])
        else $error("six second hold while working did not force soft-off");

    a_sleep_wake_up: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sys_state == pwr_pkg::CODE_SLEEPING && short_rel)
        |=> (sys_state == pwr_pkg::CODE_WORKING && pwr_en && !sleep_req))
        else $error("short press while sleeping did not wake");

    a_sleep_force_off: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sys_state == pwr_pkg::CODE_SLEEPING && long_hit)
        |=> (sys_state == pwr_pkg::CODE_SOFT_OFF))
        else $error("six second hold while sleeping did not reach soft-off");

    a_no_batt_on: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sys_state == pwr_pkg::CODE_SOFT_OFF && short_rel && !batt_s)
        |=> pwr_en)
        else $error("power-on refused without clock battery");

    a_time_loss_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(loss_now) |=> s_clear_pulse)
        else $error("battery and mains loss did not clear time and set flag");

    a_mid_press_none: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sys_state != pwr_pkg::CODE_SOFT_OFF && rel && !short_rel && !os_soft_off_req)
        |=> ($stable(sys_state) && !sleep_req))
        else $error("press between four and six seconds changed state");

    a_os_soft_off: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sys_state == pwr_pkg::CODE_WORKING && os_soft_off_req)
        |=> (sys_state == pwr_pkg::CODE_SOFT_OFF && !pwr_en))
        else $error("software soft-off request not accepted");

endmodule

//--- panel_os_model.sv
// Model of the front panel switch and the operating system
`timescale 1ns/1ns
module panel_os_model (
    // Clock
    input  wire logic core_clk,
    // Switch and operating system
    output logic      pwr_sw_n,
    output logic      os_sleep_allow,
    output logic      os_soft_off_req,
    output logic      post_ack
);
    initial begin
        pwr_sw_n        = 1'h1;
        os_sleep_allow  = 1'h1;
        os_soft_off_req = 1'h0;
        post_ack        = 1'h0;
    end

    // Contact closed for hold cycles; a released switch is pulled high
    task automatic press(input int hold);
        @(posedge core_clk);
        pwr_sw_n <= 1'h0;
        repeat (hold) @(posedge core_clk);
        pwr_sw_n <= 1'h1;
        repeat (24) @(posedge core_clk);
    endtask

    // Sleep policy of the operating system
    task automatic set_allow(input logic v);
        @(posedge core_clk);
        os_sleep_allow <= v;
    endtask

    // A single-cycle command is harder on the design than a held level
    task automatic os_off();
        @(posedge core_clk);
        os_soft_off_req <= 1'h1;
        @(posedge core_clk);
        os_soft_off_req <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask

    // Random one-cycle soft-off and ack levels and a held sleep policy, for use only where the design must ignore them
    task automatic idle_noise(input logic [2:0] v);
        @(posedge core_clk);
        os_soft_off_req <= v[0];
        post_ack        <= v[1];
        os_sleep_allow  <= v[2];
        @(posedge core_clk);
        os_soft_off_req <= 1'h0;
        post_ack        <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask

    // Boot firmware has shown the lost-time message
    task automatic ack();
        @(posedge core_clk);
        post_ack <= 1'h1;
        @(posedge core_clk);
        post_ack <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

//--- power_switch_state_control_tb_top.sv
// Self-checking bench for the power switch state control
`timescale 1ns/1ns
module power_switch_state_control_tb_top;
    logic        core_clk;
    logic        arst_n;
    logic        rtc_batt_ok;
    logic        mains_ok;
    logic        pwr_sw_n;
    logic        os_sleep_allow;
    logic        os_soft_off_req;
    logic        post_ack;
    logic [1:0]  sys_state;
    logic        pwr_en;
    logic        sleep_req;
    logic        rtc_clear;
    logic        time_lost;
    logic [5:0]  got;
    logic [5:0]  seen;
    logic [5:0]  notes[$];
    logic [15:0] lfsr;
    int          fail_count;
    int          checked;
    int          cycles;

    assign got = {sys_state, pwr_en, sleep_req, rtc_clear, time_lost};

    panel_os_model partner_u (
        .core_clk        (core_clk),
        .pwr_sw_n        (pwr_sw_n),
        .os_sleep_allow  (os_sleep_allow),
        .os_soft_off_req (os_soft_off_req),
        .post_ack        (post_ack)
    );

    // Short counts keep the run brief; expectations follow from them
    power_switch_state_control #(
        .SHORT_HOLD_CYC (40),
        .LONG_HOLD_CYC  (60),
        .DEBOUNCE_CYC   (4)
    ) dut_u (
        .core_clk        (core_clk),
        .arst_n          (arst_n),
        .pwr_sw_n        (pwr_sw_n),
        .rtc_batt_ok     (rtc_batt_ok),
        .mains_ok        (mains_ok),
        .os_sleep_allow  (os_sleep_allow),
        .os_soft_off_req (os_soft_off_req),
        .post_ack        (post_ack),
        .sys_state       (sys_state),
        .pwr_en          (pwr_en),
        .sleep_req       (sleep_req),
        .rtc_clear       (rtc_clear),
        .time_lost       (time_lost)
    );

    initial core_clk = 1'h0;
    always #50 core_clk = ~core_clk;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Expected outputs: state, then power enable, sleep, clear, lost bits
    task automatic note(input logic [1:0] st, input logic [3:0] bits);
        notes.push_back({st, bits});
    endtask

    // Press of random length in base .. base+span-1 cycles
    task automatic tap(input int base, input int span);
        lfsr = lfsr_next(lfsr);
        partner_u.press(base + int'(lfsr % span));
    endtask

    // Every change of the outputs takes the oldest note
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seen <= 6'h00;
        end else begin
            cycles++;
            if (cycles >= 4000) begin
                fail_count++;
                stop_test();
            end
            if (got !== seen) begin
                seen <= got;
                checked++;
                if (notes.size() == 0) begin
                    fail_count++;
                    $display("BAD t=%0t got=%h exp=none", $time, got);
                end else begin
                    if (got !== notes[0]) begin
                        fail_count++;
                        $display("BAD t=%0t got=%h exp=%h", $time, got, notes[0]);
                    end
                    void'(notes.pop_front());
                end
            end
        end
    end

    initial begin
        arst_n      = 1'h0;
        rtc_batt_ok = 1'h1;
        mains_ok    = 1'h1;
        fail_count  = 0;
        checked     = 0;
        cycles      = 0;
        lfsr        = 16'h0d85;
        repeat (8) @(posedge core_clk);
        arst_n <= 1'h1;
        repeat (4) @(posedge core_clk);
        note(pwr_pkg::CODE_WORKING, 4'h8);
        tap(8, 24);
        note(pwr_pkg::CODE_SLEEPING, 4'h4);
        note(pwr_pkg::CODE_SLEEPING, 4'h0);
        tap(8, 24);
        note(pwr_pkg::CODE_WORKING, 4'h8);
        tap(8, 24);
        partner_u.set_allow(1'h0);
        note(pwr_pkg::CODE_WORKING, 4'hc);
        note(pwr_pkg::CODE_WORKING, 4'h8);
        tap(8, 24);
        tap(44, 12);
        note(pwr_pkg::CODE_SOFT_OFF, 4'h0);
        partner_u.press(80);
        partner_u.press(80);
        note(pwr_pkg::CODE_WORKING, 4'h8);
        tap(8, 24);
        note(pwr_pkg::CODE_SOFT_OFF, 4'h0);
        partner_u.os_off();
        partner_u.os_off();
        // Soft-off with the battery present must ignore these; any output change has no note
        repeat (6) begin
            lfsr = lfsr_next(lfsr);
            mains_ok <= lfsr[3];
            partner_u.idle_noise(lfsr[2:0]);
        end
        mains_ok <= 1'h1;
        partner_u.set_allow(1'h1);
        note(pwr_pkg::CODE_WORKING, 4'h8);
        tap(8, 24);
        note(pwr_pkg::CODE_SLEEPING, 4'h4);
        note(pwr_pkg::CODE_SLEEPING, 4'h0);
        tap(8, 24);
        tap(44, 12);
        note(pwr_pkg::CODE_SOFT_OFF, 4'h0);
        partner_u.press(80);
        note(pwr_pkg::CODE_SOFT_OFF, 4'h3);
        note(pwr_pkg::CODE_SOFT_OFF, 4'h1);
        @(posedge core_clk);
        rtc_batt_ok <= 1'h0;
        mains_ok    <= 1'h0;
        repeat (12) @(posedge core_clk);
        mains_ok <= 1'h1;
        repeat (8) @(posedge core_clk);
        note(pwr_pkg::CODE_WORKING, 4'h9);
        tap(8, 24);
        note(pwr_pkg::CODE_WORKING, 4'h8);
        partner_u.ack();
        // Second reset with the clock battery still missing
        @(posedge core_clk);
        arst_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'h1;
        note(pwr_pkg::CODE_SOFT_OFF, 4'h3);
        note(pwr_pkg::CODE_SOFT_OFF, 4'h1);
        repeat (20) @(posedge core_clk);
        rtc_batt_ok <= 1'h1;
        repeat (10) @(posedge core_clk);
        if (notes.size() != 0) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, notes[0]);
        end
        stop_test();
    end
endmodule
